//--- logic/pcc_pkg.sv
package pcc_pkg;

  // ==========================================================
  // framing modes
  // gray coded along long, short, link, gci
  typedef enum logic [1:0] {
    PCC_LONG = 2'h0,
    PCC_SHORT = 2'h1,
    PCC_IDL = 2'h3,
    PCC_GCI = 2'h2
  } pcc_mode_t;

  // ==========================================================
  // widths, counts and reset values
  localparam int WORD_BITS = 8;
  localparam logic [5:0] CNT_ZERO = 6'h00;
  localparam logic [5:0] CNT_LAST = 6'h3e;
  localparam logic [5:0] LONG_END = 6'h07;
  localparam logic [5:0] SHORT_END = 6'h08;
  localparam logic [5:0] GCI_END = 6'h0f;
  localparam logic [5:0] IDL_B2_OFS = 6'h0a;
  localparam logic [5:0] GCI_B2_OFS = 6'h10;
  localparam logic [7:0] MU_MASK = 8'h7f;
  localparam logic [7:0] A_MASK = 8'h55;
  localparam logic [7:0] WORD_RST = 8'h00;

  // ==========================================================
  // slot decoding shared by both link directions
  function automatic logic [5:0] pcc_offset(input pcc_mode_t mode, input logic b2);
    logic [5:0] ofs;
    ofs = CNT_ZERO;
    if (b2 && mode == PCC_IDL) begin
      ofs = IDL_B2_OFS;
    end else if (b2 && mode == PCC_GCI) begin
      ofs = GCI_B2_OFS;
    end
    return ofs;
  endfunction : pcc_offset

  // falling-edge count at which the transmit line is let go
  function automatic logic [5:0] pcc_end(input pcc_mode_t mode, input logic b2);
    logic [5:0] last;
    case (mode)
      PCC_LONG: last = LONG_END;
      PCC_SHORT: last = SHORT_END;
      PCC_IDL: last = pcc_offset(mode, b2) + SHORT_END;
      PCC_GCI: last = pcc_offset(mode, b2) + GCI_END;
      default: last = SHORT_END;
    endcase
    return last;
  endfunction : pcc_end

  // {valid, bit index} launched at a rising edge
  function automatic logic [3:0] pcc_tx_slot(input pcc_mode_t mode, input logic b2,
      input logic [5:0] cnt);
    logic [5:0] ofs;
    logic [5:0] d;
    logic [3:0] slot;
    ofs = pcc_offset(mode, b2);
    d = cnt - ofs;
    slot = 4'h0;
    if (mode == PCC_GCI) begin
      d = cnt + 6'h01 - ofs;
      if (cnt + 6'h01 >= ofs && d <= GCI_END) begin
        slot = {1'b1, d[3:1]};
      end
    end else if (mode == PCC_LONG) begin
      // sign already went out early, so the edge after falling n carries bit n+1
      if (cnt < LONG_END) begin
        slot = {1'b1, cnt[2:0] + 3'h1};
      end
    end else if (cnt >= ofs && d <= LONG_END) begin
      slot = {1'b1, d[2:0]};
    end
    return slot;
  endfunction : pcc_tx_slot

  // {valid, bit index} taken into the receive word
  function automatic logic [3:0] pcc_rx_slot(input pcc_mode_t mode, input logic b2,
      input logic [5:0] cnt);
    logic [5:0] ofs;
    logic [5:0] d;
    logic [3:0] slot;
    ofs = pcc_offset(mode, b2);
    d = cnt - ofs;
    slot = 4'h0;
    case (mode)
      PCC_LONG: if (cnt <= LONG_END) slot = {1'b1, cnt[2:0]};
      PCC_GCI: if (cnt >= ofs && d <= GCI_END && !d[0]) slot = {1'b1, d[3:1]};
      default: if (cnt > ofs && d <= SHORT_END) slot = {1'b1, d[2:0] - 3'h1};
    endcase
    return slot;
  endfunction : pcc_rx_slot

  function automatic logic [7:0] pcc_mask(input logic alaw);
    return alaw ? A_MASK : MU_MASK;
  endfunction : pcc_mask

endpackage : pcc_pkg

//--- logic/pcc_frame_timer.sv
module pcc_frame_timer (
  input wire logic bit_clk,
  input wire logic rst,
  input wire logic en,
  input wire logic sync,
  output logic sync_s,
  output logic active,
  output logic [5:0] cnt
);
  import pcc_pkg::*;

  // ==========================================================
  // sync sampling on the falling bit clock edge
  always_ff @(negedge bit_clk) begin
    if (rst) begin
      sync_s <= 1'b0;
    end else if (en) begin
      sync_s <= sync;
    end
  end

  // ==========================================================
  // falling-edge counter, zero on the edge that first sees sync
  // a new sync restarts the count even mid-frame
  always_ff @(negedge bit_clk) begin
    if (rst) begin
      active <= 1'b0;
      cnt <= CNT_ZERO;
    end else if (en) begin
      if (sync && !sync_s) begin
        active <= 1'b1;
        cnt <= CNT_ZERO;
      end else if (active) begin
        cnt <= cnt + 6'h01;
        if (cnt == CNT_LAST) begin
          active <= 1'b0;
        end
      end
    end
  end

endmodule : pcc_frame_timer

//--- logic/pcc_word_xfer.sv
module pcc_word_xfer (
  input wire logic src_clk,
  input wire logic src_rst,
  input wire logic src_en,
  input wire logic src_load,
  input wire logic [7:0] src_data,
  input wire logic dst_clk,
  input wire logic dst_rst,
  input wire logic dst_en,
  output logic [7:0] dst_data,
  output logic dst_pulse
);
  import pcc_pkg::*;

  logic src_tog;
  logic [7:0] src_hold;
  logic dst_meta;
  logic dst_sync;
  logic dst_seen;

  // ==========================================================
  // source side: hold the word, flip the toggle
  always_ff @(posedge src_clk) begin
    if (src_rst) begin
      src_tog <= 1'b0;
      src_hold <= WORD_RST;
    end else if (src_en && src_load) begin
      src_tog <= ~src_tog;
      src_hold <= src_data;
    end
  end

  // ==========================================================
  // destination side
  always_ff @(posedge dst_clk) begin
    dst_meta <= src_tog;
    dst_sync <= dst_meta;
  end

  // the held word is stable by the time the toggle arrives here
  always_ff @(posedge dst_clk) begin
    if (dst_rst) begin
      dst_seen <= 1'b0;
      dst_pulse <= 1'b0;
      dst_data <= WORD_RST;
    end else if (dst_en) begin
      dst_seen <= dst_sync;
      dst_pulse <= dst_sync ^ dst_seen;
      if (dst_sync ^ dst_seen) begin
        dst_data <= src_hold;
      end
    end
  end

endmodule : pcc_word_xfer

//--- logic/pcc_codec_port.sv
// Overview of operation
// - long frame: sign bit driven at later of sync rise or clock rise
// - long frame: chord and step bits launched on rising bit clock
// - long frame: release after later of 8th falling edge or sync fall
// - short frame: each bit driven from rising edge, sign after sync
// - short frame: release after 8th falling edge from frame start
// - receive bits sampled on falling receive clock in frame-sync modes
// - frame syncs detected on falling edge of their own bit clock
// - link mode: both words in one chosen B channel, never split
// - link mode: sync sampled on falling link clock
// - link mode: receive bits captured on falling link clock
// - link mode: drive on rising clock, release on falling after last bit
// - gci mode: both words in one B channel, 8 kHz accesses
// - gci b1: drive on sync rise if clock high, else next rising clock
// - gci: release on second falling clock edge of the last bit
// - gci: receive bits sampled on rising clock
// - gci: frame pulse sampled on falling clock
// - mu-law: invert the seven magnitude bits both ways
// - a-law: invert even-numbered bits both ways
module pcc_codec_port (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire pcc_pkg::pcc_mode_t frame_mode,
  input wire logic use_b2,
  input wire logic alaw_sel,
  input wire logic [7:0] tx_sample,
  input wire logic tx_load,
  output logic [7:0] rx_sample,
  output logic rx_valid,
  input wire logic tx_bit_clock,
  input wire logic tx_frame_sync,
  output logic tx_serial_out,
  output logic tx_serial_oe,
  input wire logic rx_bit_clock,
  input wire logic rx_frame_sync,
  input wire logic rx_serial_in
);
  import pcc_pkg::*;

  // ==========================================================
  // declarations
  logic [1:0] alaw_sync;
  logic alaw;
  logic [7:0] tx_coded;
  logic tx_coded_load;
  logic [7:0] rx_xfer_data;
  logic rx_xfer_pulse;

  logic [4:0] tx_cfg_meta;
  logic [4:0] tx_cfg;
  logic tx_rst;
  logic tx_en;
  logic tx_b2;
  pcc_mode_t tx_mode;
  logic tx_fs_s;
  logic tx_active;
  logic [5:0] tx_cnt;
  logic [7:0] tx_word;
  logic tx_word_pulse;
  logic [3:0] tx_slot;
  logic tx_past_end;
  logic tx_early;
  logic tx_data;
  logic tx_drive;

  logic [4:0] rx_cfg_meta;
  logic [4:0] rx_cfg;
  logic rx_rst;
  logic rx_en;
  logic rx_b2;
  pcc_mode_t rx_mode;
  logic rx_fs_s;
  logic rx_active;
  logic [5:0] rx_cnt;
  logic [3:0] rx_slot;
  logic rx_fall;
  logic rx_bit;
  logic [7:0] rx_shift;
  logic rx_done;

  // ==========================================================
  // system clock side
  always_ff @(posedge clk) begin
    if (ce) begin
      alaw_sync <= {alaw_sync[0], alaw_sel};
    end
  end
  assign alaw = alaw_sync[1];

  always_ff @(posedge clk) begin
    if (srst) begin
      tx_coded <= WORD_RST;
      tx_coded_load <= 1'b0;
    end else if (ce) begin
      tx_coded_load <= tx_load;
      if (tx_load) begin
        tx_coded <= tx_sample ^ pcc_mask(alaw);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rx_sample <= WORD_RST;
      rx_valid <= 1'b0;
    end else if (ce) begin
      rx_valid <= rx_xfer_pulse;
      if (rx_xfer_pulse) begin
        rx_sample <= rx_xfer_data ^ pcc_mask(alaw);
      end
    end
  end

  pcc_word_xfer u_tx_xfer (
    .src_clk(clk),
    .src_rst(srst),
    .src_en(ce),
    .src_load(tx_coded_load),
    .src_data(tx_coded),
    .dst_clk(tx_bit_clock),
    .dst_rst(tx_rst),
    .dst_en(tx_en),
    .dst_data(tx_word),
    .dst_pulse(tx_word_pulse)
  );

  pcc_word_xfer u_rx_xfer (
    .src_clk(rx_bit_clock),
    .src_rst(rx_rst),
    .src_en(rx_en),
    .src_load(rx_done),
    .src_data(rx_shift),
    .dst_clk(clk),
    .dst_rst(srst),
    .dst_en(ce),
    .dst_data(rx_xfer_data),
    .dst_pulse(rx_xfer_pulse)
  );

  // ==========================================================
  // transmit bit clock domain
  // reset, enable and mode arrive through two flops; the link
  // clock must run while srst is held or this side stays stale
  always_ff @(posedge tx_bit_clock) begin
    tx_cfg_meta <= {srst, ce, use_b2, frame_mode};
    tx_cfg <= tx_cfg_meta;
  end
  assign tx_rst = tx_cfg[4];
  assign tx_en = tx_cfg[3];
  assign tx_b2 = tx_cfg[2];
  assign tx_mode = pcc_mode_t'(tx_cfg[1:0]);

  pcc_frame_timer u_tx_timer (
    .bit_clk(tx_bit_clock),
    .rst(tx_rst),
    .en(tx_en),
    .sync(tx_frame_sync),
    .sync_s(tx_fs_s),
    .active(tx_active),
    .cnt(tx_cnt)
  );

  // slot chosen by mode and channel
  assign tx_slot = pcc_tx_slot(tx_mode, tx_b2, tx_cnt);

  // release once the end count is reached
  // long frame also waits for the sampled sync to drop
  assign tx_past_end = !tx_active ||
      (tx_cnt >= pcc_end(tx_mode, tx_b2) && (tx_mode != PCC_LONG || !tx_fs_s));

  // sign bit follows whichever of sync or clock rises last
  // the clock is read as data here, so the sign needs no edge
  assign tx_early = (tx_mode == PCC_LONG || (tx_mode == PCC_GCI && !tx_b2)) &&
      tx_frame_sync && ((tx_bit_clock && tx_past_end) ||
      (tx_active && tx_cnt == CNT_ZERO));

  // launch on rising edge, hold the last bit
  always_ff @(posedge tx_bit_clock) begin
    if (tx_rst) begin
      tx_data <= 1'b0;
      tx_drive <= 1'b0;
    end else if (tx_en) begin
      tx_drive <= (tx_active && tx_slot[3]) || (tx_drive && !tx_past_end);
      if (tx_active && tx_slot[3]) begin
        tx_data <= tx_word[3'h7 - tx_slot[2:0]];
      end
    end
  end

  assign tx_serial_oe = (tx_drive && !tx_past_end) || tx_early;
  assign tx_serial_out = tx_drive ? tx_data : tx_word[7];

  // ==========================================================
  // receive bit clock domain
  always_ff @(posedge rx_bit_clock) begin
    rx_cfg_meta <= {srst, ce, use_b2, frame_mode};
    rx_cfg <= rx_cfg_meta;
  end
  assign rx_rst = rx_cfg[4];
  assign rx_en = rx_cfg[3];
  assign rx_b2 = rx_cfg[2];
  assign rx_mode = pcc_mode_t'(rx_cfg[1:0]);

  pcc_frame_timer u_rx_timer (
    .bit_clk(rx_bit_clock),
    .rst(rx_rst),
    .en(rx_en),
    .sync(rx_frame_sync),
    .sync_s(rx_fs_s),
    .active(rx_active),
    .cnt(rx_cnt)
  );

  always_ff @(negedge rx_bit_clock) begin
    if (rx_rst) begin
      rx_fall <= 1'b0;
    end else if (rx_en) begin
      rx_fall <= rx_serial_in;
    end
  end

  // receive slot for mode and channel
  assign rx_slot = pcc_rx_slot(rx_mode, rx_b2, rx_cnt);

  // gci takes the bit live at the rising edge
  assign rx_bit = (rx_mode == PCC_GCI) ? rx_serial_in : rx_fall;

  always_ff @(posedge rx_bit_clock) begin
    if (rx_rst) begin
      rx_shift <= WORD_RST;
      rx_done <= 1'b0;
    end else if (rx_en) begin
      rx_done <= rx_active && rx_slot[3] && rx_slot[2:0] == 3'h7;
      if (rx_active && rx_slot[3]) begin
        rx_shift[3'h7 - rx_slot[2:0]] <= rx_bit;
      end
    end
  end

  // ==========================================================
  // checks
  sequence s_short_start;
    tx_mode == PCC_SHORT && tx_active && tx_cnt == CNT_ZERO;
  endsequence

  // the launch edge itself samples the old enable; the eighth falling edge ends it
  sequence s_short_body;
    tx_serial_oe [*7];
  endsequence

  // short frame drives through the seven rising edges after the sign launch
  a_short_tx_window: assert property (@(posedge tx_bit_clock) disable iff (tx_rst)
    s_short_start ##0 tx_en |-> ##1 s_short_body)
    else $error("short frame transmit window wrong");

  // short frame released after eighth falling edge
  a_short_tx_release: assert property (@(posedge tx_bit_clock) disable iff (tx_rst)
    (tx_mode == PCC_SHORT && tx_active && tx_cnt == SHORT_END) |-> !tx_serial_oe)
    else $error("short frame transmit not released");

  // long frame sign bit present before any bit edge
  a_long_sign_early: assert property (@(negedge tx_bit_clock) disable iff (tx_rst)
    (tx_mode == PCC_LONG && tx_frame_sync && !tx_active) |->
    (tx_serial_oe && tx_serial_out == tx_word[7]))
    else $error("long frame sign bit not driven");

  // long frame release once sync is low past the eighth edge
  a_long_release: assert property (@(posedge tx_bit_clock) disable iff (tx_rst)
    (tx_mode == PCC_LONG && tx_active && tx_cnt > LONG_END && !tx_fs_s) |->
    !tx_serial_oe)
    else $error("long frame transmit not released");

  // a sync rise seen at a falling edge starts the count
  a_sync_detect: assert property (@(negedge tx_bit_clock) disable iff (tx_rst)
    (tx_en && tx_frame_sync && !tx_fs_s) |=> (tx_active && tx_cnt == CNT_ZERO))
    else $error("frame sync not detected");

  // gci b1 released on second falling edge of the last bit
  a_gci_release: assert property (@(posedge tx_bit_clock) disable iff (tx_rst)
    (tx_mode == PCC_GCI && !tx_b2 && tx_active && tx_cnt == GCI_END) |->
    !tx_serial_oe && $past(tx_serial_oe))
    else $error("gci transmit not released");

  // short frame sign bit comes from the falling-edge sample
  a_rx_fall_sample: assert property (@(posedge rx_bit_clock) disable iff (rx_rst)
    (rx_en && rx_mode == PCC_SHORT && rx_active && rx_cnt == 6'h01) |=>
    rx_shift[7] == $past(rx_fall))
    else $error("receive sign bit not taken");

  // gci sign bit taken at the rising edge
  a_gci_rx_rise: assert property (@(posedge rx_bit_clock) disable iff (rx_rst)
    (rx_en && rx_mode == PCC_GCI && !rx_b2 && rx_active && rx_cnt == CNT_ZERO) |=>
    rx_shift[7] == $past(rx_serial_in))
    else $error("gci receive bit not taken");

  // transmit word coded by the companding mask
  a_tx_coding: assert property (@(posedge clk) disable iff (srst)
    (ce && tx_load) |=> tx_coded == ($past(tx_sample) ^ pcc_mask(alaw)))
    else $error("transmit coding wrong");

  // a finished receive word reaches the system side
  a_rx_delivery: assert property (@(posedge clk) disable iff (srst)
    (ce && rx_xfer_pulse) |=> (rx_valid && rx_sample == ($past(rx_xfer_data) ^
    pcc_mask(alaw))))
    else $error("receive word not delivered");

endmodule : pcc_codec_port

//--- dv/pcc_tdm_master.sv
// ==========================================================
// far-side frame master: free-running bit clock, sync, receive line
module pcc_tdm_master (
  output logic bclk,
  output logic sync,
  output logic rx_line,
  input wire logic tx_out,
  input wire logic tx_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  import pcc_pkg::*;

  // one sync every 125 us of the 64 ns clock
  localparam int FRAME_CLKS = 1953;
  localparam int SPAN = 40;

  initial begin
    bclk = 1'b0;
    sync = 1'b0;
    rx_line = 1'b0;
    forever #32 bclk = ~bclk;
  end

  // ==========================================================
  // one frame: period n runs from rising edge n to falling edge n
  task automatic run_frame(input pcc_mode_t mode, input logic b2, input logic [7:0] word,
      output logic [7:0] seen, output int bad);
    int f;
    int last;
    int step;
    int k;
    logic gci;
    logic slot;
    gci = (mode == PCC_GCI);
    step = gci ? 2 : 1;
    f = (mode == PCC_LONG || gci) ? 0 : 1;
    if (b2 && mode == PCC_IDL) f = f + 10;
    if (b2 && gci) f = f + 16;
    last = f + (gci ? 15 : 7);
    seen = 8'h00;
    bad = 0;
    repeat (FRAME_CLKS - SPAN) @(posedge bclk);
    for (int n = 0; n < SPAN; n++) begin
      @(posedge bclk);
      #2;
      slot = (n >= f) && (n < f + 8 * step) && ((n - f) % step == 0);
      k = slot ? (n - f) / step : 0;
      sync = (n == 0) || (n == 1 && mode == PCC_LONG);
      // released data line toggles so a stale bit never passes
      if (!gci) rx_line = slot ? word[7 - k] : ~rx_line;
      #28;
      if (slot) seen[7 - k] = tx_out;
      if (tx_oe !== (n >= f && n <= last)) bad++;
      @(negedge bclk);
      #2;
      if (gci) rx_line = slot ? word[7 - k] : ~rx_line;
    end
  endtask : run_frame
endmodule : pcc_tdm_master

//--- dv/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import pcc_pkg::*;

  logic clk;
  logic srst;
  logic ce;
  pcc_mode_t frame_mode;
  logic use_b2;
  logic alaw_sel;
  logic [7:0] tx_sample;
  logic tx_load;
  logic [7:0] rx_sample;
  logic rx_valid;
  logic bclk;
  logic fsync;
  logic rx_line;
  logic tx_serial_out;
  logic tx_serial_oe;
  int miscompares;
  int n_compared;
  int seed;
  int bad;
  logic [7:0] tx_word;
  logic [7:0] rx_word;
  logic [7:0] mask;
  logic [7:0] seen;
  logic [7:0] rxq[$];
  pcc_mode_t modes [8] = '{PCC_LONG, PCC_SHORT, PCC_IDL, PCC_IDL, PCC_GCI, PCC_GCI,
      PCC_LONG, PCC_SHORT};

  // link sides share one clock and sync as the link modes demand
  pcc_codec_port i_dut (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .frame_mode(frame_mode),
    .use_b2(use_b2),
    .alaw_sel(alaw_sel),
    .tx_sample(tx_sample),
    .tx_load(tx_load),
    .rx_sample(rx_sample),
    .rx_valid(rx_valid),
    .tx_bit_clock(bclk),
    .tx_frame_sync(fsync),
    .tx_serial_out(tx_serial_out),
    .tx_serial_oe(tx_serial_oe),
    .rx_bit_clock(bclk),
    .rx_frame_sync(fsync),
    .rx_serial_in(rx_line)
  );

  pcc_tdm_master i_host (
    .bclk(bclk),
    .sync(fsync),
    .rx_line(rx_line),
    .tx_out(tx_serial_out),
    .tx_oe(tx_serial_oe)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // every delivered word is queued so none slips past unseen
  always @(posedge clk) begin
    if (rx_valid === 1'b1) rxq.push_back(rx_sample);
  end

  // ==========================================================
  // comparison and verdict
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic complete_run;
    if (miscompares == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    #5ms;
    miscompares++;
    complete_run();
  end

  // ==========================================================
  // each configuration under its own reset, three frames each
  initial begin
    miscompares = 0;
    n_compared = 0;
    seed = 39340;
    srst = 1'b1;
    ce = 1'b1;
    frame_mode = PCC_LONG;
    use_b2 = 1'b0;
    alaw_sel = 1'b0;
    tx_sample = 8'h00;
    tx_load = 1'b0;
    for (int c = 0; c < 8; c++) begin
      @(negedge clk);
      srst = 1'b1;
      frame_mode = modes[c];
      use_b2 = (c == 3) || (c == 5);
      alaw_sel = c[0] ^ (c > 5);
      mask = alaw_sel ? A_MASK : MU_MASK;
      repeat (5) @(negedge clk);
      srst = 1'b0;
      check(rx_sample, WORD_RST, "reset word");
      check({7'h00, tx_serial_oe}, 8'h00, "reset enable");
      for (int f = 0; f < 3; f++) begin
        tx_word = 8'($random(seed));
        rx_word = 8'($random(seed));
        // a load offered while frozen must leave no trace
        @(negedge clk);
        ce = 1'b0;
        tx_sample = ~tx_word;
        tx_load = 1'b1;
        @(negedge clk);
        ce = 1'b1;
        tx_sample = tx_word;
        @(negedge clk);
        tx_load = 1'b0;
        rxq.delete();
        i_host.run_frame(frame_mode, use_b2, rx_word, seen, bad);
        for (int w = 0; w < 20 && rxq.size() == 0; w++) @(negedge clk);
        check(seen, tx_word ^ mask, "tx word");
        check(8'(bad), 8'h00, "drive window");
        check(8'(rxq.size()), 8'h01, "rx count");
        if (rxq.size() > 0) check(rxq[0], rx_word ^ mask, "rx word");
      end
    end
    complete_run();
  end
endmodule : testbench
